// ---- quad_dac_regs.svh ----
// constants for the quad converter serial load logic
`ifndef QUAD_DAC_REGS_SVH
`define QUAD_DAC_REGS_SVH

// ----------------------------------------------------------------
// word layout
// ----------------------------------------------------------------
`define WORD_BITS 12
`define CODE_BITS 8
`define CHANNELS 4
`define SHUT_ALL_POS 11
`define SHUT_SEL_POS 10
`define SEL_HI_POS 9
`define SEL_LO_POS 8

// ----------------------------------------------------------------
// reset values and the all channels off mask
// ----------------------------------------------------------------
`define CODE_ZERO 8'h00
`define SHIFT_RESET 12'h000
`define OFF_RESET 4'h0
`define OFF_ALL 4'hF

`endif

// ---- quad_dac_pkg.sv ----
// types shared by the quad converter serial load logic
`include "quad_dac_regs.svh"

package quad_dac_pkg;

  // one serial command word, first bit shifted in at the top
  typedef struct packed {
    logic shutdown_all_bit_n;
    logic shutdown_selected_bit_n;
    logic channel_select_hi;
    logic channel_select_lo;
    logic [`CODE_BITS-1:0] code_bits;
  } cmd_word_t;

  typedef logic [`CHANNELS-1:0][`CODE_BITS-1:0] code_bank_t;

  typedef logic [`CHANNELS-1:0] chan_mask_t;

endpackage

// ---- quad_dac_serial_load_logic.sv ----
// serial front end and code registers of a four channel converter
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// two flop synchroniser
// ----------------------------------------------------------------
// one instance per control pin from outside i_mclk (select, load, clear, float), not sclk or sdi; pulses shorter than one
// system clock period may be lost
module bit_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_async,
  output logic o_sync
);

  logic meta;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      meta <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule

// ----------------------------------------------------------------
// top
// ----------------------------------------------------------------
module quad_dac_serial_load_logic (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  input wire logic i_load_outputs_strobe_n,
  input wire logic i_clear_all_n,
  input wire logic i_float_shutdown_request,
  output quad_dac_pkg::code_bank_t o_input_code,
  output quad_dac_pkg::code_bank_t o_dac_code,
  output quad_dac_pkg::chan_mask_t o_channel_off
);

  import quad_dac_pkg::*;

  // ----------------------------------------------------------------
  // serial clock domain
  // ----------------------------------------------------------------
  // the host frames data with select, so select and data are
  // sampled on the serial edge itself; the clock stops between frames

  cmd_word_t shift_reg;
  cmd_word_t next_shift;

  always_comb begin
    next_shift = shift_reg;
    if (!i_cs_n) begin
      next_shift = cmd_word_t'({shift_reg[`WORD_BITS-2:0], i_sdi});
    end
  end

  // clear does not reach this register
  // only the reset pin zeroes it, so a word survives a clear
  always_ff @(posedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      shift_reg <= `SHIFT_RESET;
    end else begin
      shift_reg <= next_shift;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic cs_s;
  logic load_s_n;
  logic clear_s_n;
  logic float_s;

  // select passes these flops only to find its rising edge; the word
  // itself never goes through them
  bit_sync #(.RESET_VAL(1'b1)) sync_cs (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_async(i_cs_n),
    .o_sync(cs_s)
  );

  bit_sync #(.RESET_VAL(1'b1)) sync_load (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_async(i_load_outputs_strobe_n),
    .o_sync(load_s_n)
  );

  bit_sync #(.RESET_VAL(1'b1)) sync_clear (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_async(i_clear_all_n),
    .o_sync(clear_s_n)
  );

  bit_sync #(.RESET_VAL(1'b0)) sync_float (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_async(i_float_shutdown_request),
    .o_sync(float_s)
  );

  // ----------------------------------------------------------------
  // word transfer and code registers
  // ----------------------------------------------------------------
  // the word crosses as a bus qualified by synchronised select:
  // once select is high the serial side is frozen, so it is stable
  // limitation: select reopened within three system cycles may lose it

  logic cs_d;
  logic cs_rise;
  logic [1:0] sel;
  logic all_off;
  chan_mask_t chan_off;
  code_bank_t in_code;
  code_bank_t dac_code;
  chan_mask_t off;

  logic next_cs_d;
  logic next_all;
  chan_mask_t next_chan;
  code_bank_t next_in;
  code_bank_t next_dac;
  chan_mask_t next_off;

  assign cs_rise = cs_s & ~cs_d;
  assign sel = {shift_reg.channel_select_hi,
                shift_reg.channel_select_lo};

  always_comb begin
    next_cs_d = cs_s;
    next_in = in_code;
    next_dac = dac_code;
    next_all = all_off;
    next_chan = chan_off;
    if (cs_rise) begin
      next_in[sel] = shift_reg.code_bits;
      next_all = ~shift_reg.shutdown_all_bit_n;
      next_chan[sel] = ~shift_reg.shutdown_selected_bit_n;
    end
    // one cycle of lag from the input rank is accepted
    if (!load_s_n) begin
      next_dac = in_code;
    end
    // clear overrides a load and the code of a transfer, not its shutdown bits
    if (!clear_s_n) begin
      for (int i = 0; i < `CHANNELS; i++) begin
        next_in[i] = `CODE_ZERO;
        next_dac[i] = `CODE_ZERO;
      end
    end
    // shutdown only gates the outputs, codes are untouched
    next_off = {`CHANNELS{next_all}} | next_chan
      | {`CHANNELS{float_s}};
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    // cs_d resets high like the select pin at rest, so leaving reset
    // makes no false select edge
    if (i_reset) begin
      cs_d <= 1'b1;
      all_off <= 1'b0;
      chan_off <= `OFF_RESET;
      off <= `OFF_RESET;
      for (int i = 0; i < `CHANNELS; i++) begin
        in_code[i] <= `CODE_ZERO;
        dac_code[i] <= `CODE_ZERO;
      end
    end else begin
      cs_d <= next_cs_d;
      all_off <= next_all;
      chan_off <= next_chan;
      off <= next_off;
      in_code <= next_in;
      dac_code <= next_dac;
    end
  end

  assign o_input_code = in_code;
  assign o_dac_code = dac_code;
  assign o_channel_off = off;

  // ----------------------------------------------------------------
  // checks, serial side
  // ----------------------------------------------------------------
  // sampled on i_sclk, so they only see edges the host really sends

  a_shift_advance:
    assert property (@(posedge i_sclk) disable iff (i_reset)
      !i_cs_n |=> shift_reg == cmd_word_t'(
        {$past(shift_reg[`WORD_BITS-2:0]), $past(i_sdi)}))
    else $error("shift register did not advance");

  a_shift_frozen:
    assert property (@(posedge i_sclk) disable iff (i_reset)
      i_cs_n |=> $stable(shift_reg))
    else $error("shift register moved while deselected");

  // ----------------------------------------------------------------
  // checks, system side
  // ----------------------------------------------------------------

  // these run on i_mclk and see the pins through the synchronisers,
  // so every check lags the pins by two cycles

  sequence word_end;
    cs_rise && clear_s_n;
  endsequence

  sequence load_open;
    !load_s_n && clear_s_n;
  endsequence

  a_clear_zero:
    assert property (@(posedge i_mclk) disable iff (i_reset)
      !clear_s_n |=> in_code == '0 && dac_code == '0)
    else $error("clear did not zero the codes");

  a_word_store:
    assert property (@(posedge i_mclk) disable iff (i_reset)
      word_end |=>
      in_code[$past(sel)] == $past(shift_reg.code_bits))
    else $error("word code not stored in selected register");

  a_input_hold:
    assert property (@(posedge i_mclk) disable iff (i_reset)
      !cs_rise && clear_s_n |=> $stable(in_code))
    else $error("input register changed without a word");

  a_load_copy:
    assert property (@(posedge i_mclk) disable iff (i_reset)
      load_open |=> dac_code == $past(in_code))
    else $error("output codes did not follow input codes");

  a_load_level:
    assert property (@(posedge i_mclk) disable iff (i_reset)
      load_s_n && clear_s_n |=> $stable(dac_code))
    else $error("output codes changed while load high");

  a_all_down:
    assert property (@(posedge i_mclk) disable iff (i_reset)
      word_end ##0 !shift_reg.shutdown_all_bit_n
      |=> ##1 o_channel_off == `OFF_ALL)
    else $error("shutdown all did not take every channel");

  a_sel_down:
    assert property (@(posedge i_mclk) disable iff (i_reset)
      cs_rise && !shift_reg.shutdown_selected_bit_n
      |=> ##1 o_channel_off[$past(sel, 2)])
    else $error("addressed channel not shut down");

  a_wake_up:
    assert property (@(posedge i_mclk) disable iff (i_reset)
      cs_rise && shift_reg.shutdown_all_bit_n
      && shift_reg.shutdown_selected_bit_n && !float_s
      ##1 !float_s && !cs_rise
      |=> !o_channel_off[$past(sel, 2)])
    else $error("addressed channel did not wake");

  a_float_down:
    assert property (@(posedge i_mclk) disable iff (i_reset)
      float_s |=> o_channel_off == `OFF_ALL)
    else $error("floating data pin did not shut down");

  a_codes_kept:
    assert property (@(posedge i_mclk) disable iff (i_reset)
      float_s && load_s_n && clear_s_n
      |=> $stable(dac_code))
    else $error("shutdown disturbed the output codes");

endmodule

`default_nettype wire

// ---- quad_dac_host_model.sv ----
// host side serial master model for the quad converter
`timescale 1ns/1ns
`default_nettype none
module quad_dac_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi
);
  // ----------------------------------------------------------------
  // frame driver
  // ----------------------------------------------------------------
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b1;
  end

  // clock stands still between frames; select held long enough
  // for the system clock side to see every edge of it
  task automatic send(input logic [15:0] w, input int n);
    o_cs_n = 1'b0;
    #30;
    for (int i = n - 1; i >= 0; i--) begin
      o_sdi = w[i];
      #7 o_sclk = 1'b1;
      #8 o_sclk = 1'b0;
    end
    #7 o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    #50;
  endtask

  // clock edges with select high, which the shift register must ignore
  task automatic idle_edges(input int n);
    for (int i = 0; i < n; i++) begin
      o_sdi = ~o_sdi;
      #7 o_sclk = 1'b1;
      #8 o_sclk = 1'b0;
    end
    #50;
  endtask
endmodule
`default_nettype wire

// ---- quad_dac_serial_load_logic_bench.sv ----
// self-checking bench for the quad converter serial load logic
`timescale 1ns/1ns
`default_nettype none
module quad_dac_serial_load_logic_bench;
  import quad_dac_pkg::*;
  logic i_mclk, i_reset, ld_n, clear_n, flt, sclk, cs_n, sdi, all_off;
  code_bank_t in_code, dac_code, exp_in, exp_dac;
  chan_mask_t off, chf, exp_off;
  int err_count, total_checks;

  quad_dac_serial_load_logic dut (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_sdi(sdi), .i_load_outputs_strobe_n(ld_n), .i_clear_all_n(clear_n),
    .i_float_shutdown_request(flt), .o_input_code(in_code),
    .o_dac_code(dac_code), .o_channel_off(off));
  quad_dac_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // pins are synchronised, so wait out the sync stages first
  task automatic upd();
    repeat (3) @(posedge i_mclk);
    #1;
    exp_off = {4{all_off}} | chf | {4{flt}};
    if (!ld_n) exp_dac = exp_in;
    check(in_code, exp_in);
    check(dac_code, exp_dac);
    check({28'h0, off}, {28'h0, exp_off});
  endtask

  task automatic wr(input logic [1:0] sel, input logic [7:0] code,
                    input logic sac_n, input logic sdc_n, input int extra);
    cmd_word_t w;
    w = {sac_n, sdc_n, sel, code};
    host.send({4'hC, w}, 12 + extra);
    exp_in[sel] = code;
    all_off = ~sac_n;
    chf[sel] = ~sdc_n;
    upd();
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    test_done();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    i_reset = 1'b1;
    ld_n = 1'b1;
    clear_n = 1'b1;
    flt = 1'b0;
    all_off = 1'b0;
    exp_in = '0;
    exp_dac = '0;
    chf = '0;
    err_count = 0;
    total_checks = 0;
    repeat (6) @(posedge i_mclk);
    i_reset <= 1'b0;
    repeat (3) @(posedge i_mclk);
    for (int c = 0; c < 4; c++) begin
      wr(c[1:0], 8'hA5 ^ c[7:0], 1'b1, 1'b1, 0);
    end
    $display("test store done");
    @(posedge i_mclk) ld_n <= 1'b0;
    upd();
    wr(2'h0, 8'h3C, 1'b1, 1'b1, 0);
    @(posedge i_mclk) ld_n <= 1'b1;
    upd();
    wr(2'h1, 8'hFF, 1'b1, 1'b1, 0);
    $display("test load done");
    wr(2'h2, 8'h81, 1'b1, 1'b0, 0);
    wr(2'h3, 8'h7E, 1'b0, 1'b1, 0);
    wr(2'h0, 8'h01, 1'b1, 1'b1, 2);
    @(posedge i_mclk) flt <= 1'b1;
    upd();
    @(posedge i_mclk) flt <= 1'b0;
    upd();
    $display("test shutdown done");
    @(posedge i_mclk) clear_n <= 1'b0;
    exp_in = '0;
    exp_dac = '0;
    upd();
    @(posedge i_mclk) clear_n <= 1'b1;
    upd();
    // edges with select high must leave the last word in place
    host.idle_edges(3);
    // a select pulse with no clock edges stores the untouched word
    host.send(16'h0, 0);
    exp_in[0] = 8'h01;
    upd();
    $display("test clear done");
    test_done();
  end
endmodule
`default_nettype wire
